// >>> hdl/xas_pkg.sv
// xas_pkg: constants for the external-data access steering block
// assumes an 8-bit special function register bus on the cpu machine clock
package xas_pkg;
  // ---------------------------------------------------------------
  // register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  XAS_PAGE_ADDR      = 8'h91;
  localparam logic [7:0]  XAS_PAGE_RESET     = 8'h00;
  localparam logic [7:0]  XAS_PORT2_ADDR     = 8'ha0;
  localparam logic [7:0]  XAS_PORT2_RESET    = 8'hff;
  localparam logic [7:0]  XAS_SYSTEM_CONTROL_REGISTER_ADDR    = 8'hb1;
  localparam int          XAS_VIS_BIT        = 1;
  localparam int          XAS_DIS_BIT        = 0;
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam logic [7:0]  XAS_ONCHIP_PAGE    = 8'hf7;
  localparam logic [15:0] XAS_CAN_LO         = 16'hf700;
  localparam logic [15:0] XAS_RAM_LO         = 16'hf800;
  localparam int          XAS_RAM_AW         = 11;
  // move phases, gray along idle-first-second
  typedef enum logic [1:0] {XAS_IDLE = 2'b00, XAS_CYC1 = 2'b01, XAS_CYC2 = 2'b11} xas_state_t;
endpackage

// >>> hdl/xas_steering.sv
// xas_steering: steers external-data moves to on-chip ram, can window or external bus
// assumes cpu issues one move request pulse and holds address/data for two cycles
`timescale 1ns/1ns
// Operation
// - the page register supplies a15-a8 for index-register moves to on-chip space.
// - writing the port 2 latch also loads the page register with the same byte.
// - writing the page register directly leaves the port 2 latch unchanged.
// - an address outside the on-chip range gives an external bus access.
// - index-register moves reach on-chip space only with page at or above f7.
// - reset never clears the on-chip ram array.
// - reset in the first move cycle keeps the old value, in the second writes new.
// - pointer moves below the range use external memory, both ports as bus, strobes on.
// - enabled in-range pointer moves use ram or can, strobes only when visible, ports bus when visible or pin low.
// - index moves below the page range go external, port 0 bus, port 2 i/o, strobes on.
// - enabled in-range index moves use ram or can, port 2 i/o, strobes when visible.
// - with access disabled in-range moves go external; port 2 bus only for pointer moves.
// - internal accesses put on the bus show the written data on the port pins.
// - the disable bit is set only by reset and software can only clear it.
// - f800-ffff decode as ram and f700-f7ff as can registers when enabled.
module xas_steering
#(
  parameter int RAM_AW = xas_pkg::XAS_RAM_AW
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  input  wire logic        i_sfr_we,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic [7:0]       o_sfr_rdata,
  input  wire logic        i_move,
  input  wire logic        i_move_wr,
  input  wire logic        i_move_ptr,
  input  wire logic [15:0] i_data_pointer,
  input  wire logic [7:0]  i_index_register,
  input  wire logic [7:0]  i_move_wdata,
  input  wire logic        i_external_access_pin,
  input  wire logic [7:0]  i_ext_rdata,
  output logic [7:0]       o_move_rdata,
  output logic             o_move_done,
  output logic             o_can_sel,
  output logic [7:0]       o_high_address_port,
  output logic [15:0]      o_bus_addr,
  output logic [7:0]       o_bus_wdata,
  output logic             o_p0_bus,
  output logic             o_p2_bus,
  output logic             o_rd_b,
  output logic             o_wr_b
);
  import xas_pkg::*;

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic ea_s1;
  logic ea_s2;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      ea_s1 <= 1'b0;
      ea_s2 <= 1'b0;
    end
    else if (i_ce)
    begin
      ea_s1 <= i_external_access_pin;
      ea_s2 <= ea_s1;
    end
  end

  // ---------------------------------------------------------------
  // special function registers
  // ---------------------------------------------------------------
  logic [7:0] xdata_page_high_address;
  logic [7:0] next_page;
  logic [7:0] port2_latch;
  logic [7:0] next_port2;
  logic       onchip_access_disable;
  logic       next_dis;
  logic       internal_access_visibility;
  logic       next_vis;

  // port 2 writes shadow into the page; page writes stay local
  always_comb
  begin
    next_page = xdata_page_high_address;
    next_port2 = port2_latch;
    next_dis = onchip_access_disable;
    next_vis = internal_access_visibility;
    if (i_sfr_we && i_sfr_addr == XAS_PORT2_ADDR)
    begin
      next_port2 = i_sfr_wdata;
      next_page = i_sfr_wdata;
    end
    if (i_sfr_we && i_sfr_addr == XAS_PAGE_ADDR)
      next_page = i_sfr_wdata;
    if (i_sfr_we && i_sfr_addr == XAS_SYSTEM_CONTROL_REGISTER_ADDR)
    begin
      next_vis = i_sfr_wdata[XAS_VIS_BIT];
      // asymmetric latch: a one written by software is ignored
      next_dis = onchip_access_disable & i_sfr_wdata[XAS_DIS_BIT];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      xdata_page_high_address <= XAS_PAGE_RESET;
      port2_latch <= XAS_PORT2_RESET;
      onchip_access_disable <= 1'b1;
      internal_access_visibility <= 1'b0;
    end
    else if (i_ce)
    begin
      xdata_page_high_address <= next_page;
      port2_latch <= next_port2;
      onchip_access_disable <= next_dis;
      internal_access_visibility <= next_vis;
    end
  end

  // register read mux, unmapped addresses read zero
  always_comb
  begin
    unique case (i_sfr_addr)
      XAS_PAGE_ADDR:   o_sfr_rdata = xdata_page_high_address;
      XAS_PORT2_ADDR:  o_sfr_rdata = port2_latch;
      XAS_SYSTEM_CONTROL_REGISTER_ADDR: o_sfr_rdata = {6'h00, internal_access_visibility, onchip_access_disable};
      default:         o_sfr_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // address formation and decode
  // ---------------------------------------------------------------
  logic [15:0] eff_addr;
  logic        in_range;
  logic        onchip;
  logic        is_can;
  // index moves take the page as the high byte
  assign eff_addr = i_move_ptr ? i_data_pointer
                               : {xdata_page_high_address, i_index_register};
  // page compare equals the 16-bit compare for index moves
  assign in_range = i_move_ptr ? (i_data_pointer >= XAS_CAN_LO)
                               : (xdata_page_high_address >= XAS_ONCHIP_PAGE);
  assign onchip = in_range && !onchip_access_disable;
  assign is_can = eff_addr < XAS_RAM_LO;

  // ---------------------------------------------------------------
  // two-cycle move sequencer
  // ---------------------------------------------------------------
  xas_state_t  state;
  xas_state_t  next_state;
  logic [15:0] m_addr;
  logic [15:0] next_m_addr;
  logic [7:0]  m_wdata;
  logic [7:0]  next_m_wdata;
  logic        m_wr;
  logic        next_m_wr;
  logic        m_ptr;
  logic        next_m_ptr;
  logic        m_on;
  logic        next_m_on;
  logic        m_can;
  logic        next_m_can;

  always_comb
  begin
    next_state = state;
    next_m_addr = m_addr;
    next_m_wdata = m_wdata;
    next_m_wr = m_wr;
    next_m_ptr = m_ptr;
    next_m_on = m_on;
    next_m_can = m_can;
    unique case (state)
      XAS_IDLE:
        if (i_move)
        begin
          next_state = XAS_CYC1;
          next_m_addr = eff_addr;
          next_m_wdata = i_move_wdata;
          next_m_wr = i_move_wr;
          next_m_ptr = i_move_ptr;
          next_m_on = onchip;
          next_m_can = is_can;
        end
      XAS_CYC1: next_state = XAS_CYC2;
      XAS_CYC2: next_state = XAS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      state <= XAS_IDLE;
      m_addr <= 16'h0000;
      m_wdata <= 8'h00;
      m_wr <= 1'b0;
      m_ptr <= 1'b0;
      m_on <= 1'b0;
      m_can <= 1'b0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      m_addr <= next_m_addr;
      m_wdata <= next_m_wdata;
      m_wr <= next_m_wr;
      m_ptr <= next_m_ptr;
      m_on <= next_m_on;
      m_can <= next_m_can;
    end
  end

  // ---------------------------------------------------------------
  // on-chip ram, no reset so contents survive reset
  // ---------------------------------------------------------------
  logic [7:0] ram [0:(1<<RAM_AW)-1];
  logic       ram_we;
  // commit only in the second cycle; reset in the first sends the sequencer back to idle,
  // so the write is lost, while reset seen in the second cycle still lets the new byte land
  assign ram_we = (state == XAS_CYC2) && m_on && !m_can && m_wr;
  always_ff @(posedge i_mclk)
  begin
    if (i_ce && ram_we)
      ram[m_addr[RAM_AW-1:0]] <= m_wdata;
  end

  logic [7:0] rdata;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      rdata <= 8'h00;
    else if (i_ce && state == XAS_CYC2 && !m_wr)
      rdata <= m_on ? (m_can ? 8'h00 : ram[m_addr[RAM_AW-1:0]]) : i_ext_rdata;
  end
  assign o_move_rdata = rdata;

  // ---------------------------------------------------------------
  // port roles and strobes
  // ---------------------------------------------------------------
  logic active;
  logic strobe;
  logic p0b;
  logic p2b;
  assign active = state != XAS_IDLE;
  always_comb
  begin
    if (!m_on)
    begin
      strobe = 1'b1;
      p0b = 1'b1;
      p2b = m_ptr;
    end
    else
    begin
      strobe = internal_access_visibility;
      p0b = internal_access_visibility || !ea_s2;
      p2b = m_ptr && p0b;
    end
  end

  assign o_p0_bus = active && p0b;
  assign o_p2_bus = active && p2b;
  assign o_rd_b = !(active && strobe && !m_wr);
  assign o_wr_b = !(active && strobe && m_wr);
  assign o_bus_addr = m_addr;
  // written data is shown on port 0 even for on-chip targets
  assign o_bus_wdata = m_wdata;
  assign o_high_address_port = port2_latch;
  assign o_can_sel = active && m_on && m_can;
  assign o_move_done = state == XAS_CYC2;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_dis_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !$past(onchip_access_disable) |-> !onchip_access_disable)
    else $error("disable bit set by software");
  a_port2_shadow: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_ce && i_sfr_we && i_sfr_addr == XAS_PORT2_ADDR |=> xdata_page_high_address == $past(i_sfr_wdata))
    else $error("port 2 write missed page");
  a_page_only: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_ce && i_sfr_we && i_sfr_addr == XAS_PAGE_ADDR |=> $stable(port2_latch))
    else $error("page write touched port 2");
  a_low_page_ext: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == XAS_IDLE && i_move && !i_move_ptr && xdata_page_high_address < XAS_ONCHIP_PAGE
    |=> !o_p2_bus && o_p0_bus && !(o_rd_b && o_wr_b))
    else $error("low page not external");
  a_ptr_low_ext: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == XAS_IDLE && i_move && i_move_ptr && i_data_pointer < XAS_CAN_LO
    |=> o_p0_bus && o_p2_bus && !m_on)
    else $error("low pointer not external");
  a_hidden_ram: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    active && m_on && !internal_access_visibility |-> o_rd_b && o_wr_b)
    else $error("strobe on hidden access");
  a_dis_ext: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    state == XAS_IDLE && i_move && onchip_access_disable |=> !m_on && o_p0_bus)
    else $error("disabled access went on-chip");
  a_two_cycle: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_ce && state == XAS_IDLE && i_move ##1 i_ce[*1] |=> o_move_done)
    else $error("move not two cycles");
  a_ea_hide: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    active && m_on && ea_s2 && !internal_access_visibility |-> !o_p0_bus && !o_p2_bus)
    else $error("ports left i/o role");
endmodule // xas_steering

// >>> verification/test_xas_steering.sv
// test_xas_steering: register writes and move sequences with expected results
// assumes xas_ext_mem as the external memory; clock enable held high
`timescale 1ns/1ns
module test_xas_steering;
  import xas_pkg::*;
  logic        i_mclk = 0, i_rst_b = 0, we = 0, mv = 0, mwr = 0, mptr = 0, ea = 0;
  logic [7:0]  sa = 0, sd = 0, ix = 0, wd = 0, srd, rdat, ext_rd, port2, bwd;
  logic [15:0] dp = 0, baddr;
  logic        done, can, p0, p2, rdb, wrb;
  int          n_fail = 0, checks = 0, cyc = 0;

  always #4 i_mclk = ~i_mclk;

  xas_steering xas_steering_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(1'b1),
    .i_sfr_we(we), .i_sfr_addr(sa), .i_sfr_wdata(sd), .o_sfr_rdata(srd), .i_move(mv),
    .i_move_wr(mwr), .i_move_ptr(mptr), .i_data_pointer(dp), .i_index_register(ix),
    .i_move_wdata(wd), .i_external_access_pin(ea), .i_ext_rdata(ext_rd),
    .o_move_rdata(rdat), .o_move_done(done), .o_can_sel(can), .o_high_address_port(port2),
    .o_bus_addr(baddr), .o_bus_wdata(bwd), .o_p0_bus(p0), .o_p2_bus(p2), .o_rd_b(rdb),
    .o_wr_b(wrb));
  xas_ext_mem xas_ext_mem_i (.i_mclk(i_mclk), .i_rd_b(rdb), .i_wr_b(wrb), .i_addr(baddr),
    .i_wdata(bwd), .o_rdata(ext_rd));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task finish_test;
    if (n_fail == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task sw(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    we = 1'b1;
    sa = a;
    sd = d;
    @(negedge i_mclk);
    we = 1'b0;
  endtask

  task rr(input string n, input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge i_mclk);
    sa = a;
    #1 chk(n, e, srd & m);
  endtask

  // roles seen in cycle 1: {any strobe, port 0 bus, port 2 bus, can select}
  // rc picks a reset in cycle 1 or 2; afterwards on-chip access is enabled again
  task move(input logic w, input logic p, input logic [15:0] a, input logic [7:0] d,
            input int rc, input logic [3:0] er);
    @(negedge i_mclk);
    mv = 1'b1;
    mwr = w;
    mptr = p;
    dp = a;
    ix = a[7:0];
    wd = d;
    @(negedge i_mclk);
    mv = 1'b0;
    chk("roles", {4'h0, er}, {4'h0, ~(rdb & wrb), p0, p2, can});
    if (er[3] && w) chk("bus data", d, bwd);
    chk("bus addr lo", a[7:0], baddr[7:0]);
    if (p) chk("bus addr hi", a[15:8], baddr[15:8]);
    if (rc == 1) i_rst_b = 1'b0;
    @(negedge i_mclk);
    if (rc == 2) i_rst_b = 1'b0;
    else if (rc == 0) chk("done", 8'h01, {7'h0, done});
    @(negedge i_mclk);
    if (rc != 0)
    begin
      repeat (2) @(negedge i_mclk);
      i_rst_b = 1'b1;
      sw(XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h00);
    end
  endtask

  // hang guard, far above the hundred or so cycles the sequence needs
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      finish_test;
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge i_mclk);
    i_rst_b = 1'b1;
    rr("page", XAS_PAGE_ADDR, XAS_PAGE_RESET, 8'hff);
    rr("system_control_register", XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h01, 8'h03);
    rr("unmapped", 8'h90, 8'h00, 8'hff);
    sw(XAS_PAGE_ADDR, 8'hf8);
    move(1, 1, 16'hf830, 8'h55, 0, 4'he);
    move(0, 0, 16'hf830, 8'h00, 0, 4'hc);
    chk("ext rdata", 8'h55, rdat);
    sw(XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h00);
    sw(XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h01);
    rr("system_control_register", XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h00, 8'h03);
    move(1, 1, 16'hf830, 8'ha5, 0, 4'h6);
    move(0, 0, 16'hf830, 8'h00, 0, 4'h4);
    chk("ram rdata", 8'ha5, rdat);
    sw(XAS_PORT2_ADDR, 8'haa);
    chk("port2", 8'haa, port2);
    rr("page", XAS_PAGE_ADDR, 8'haa, 8'hff);
    move(0, 0, 16'h0030, 8'h00, 0, 4'hc);
    sw(XAS_PAGE_ADDR, 8'hf8);
    chk("port2", 8'haa, port2);
    move(0, 0, 16'h0030, 8'h00, 0, 4'h4);
    chk("ram rdata", 8'ha5, rdat);
    sw(XAS_PAGE_ADDR, 8'hf7);
    move(0, 0, 16'h0000, 8'h00, 0, 4'h5);
    chk("can rdata", 8'h00, rdat);
    sw(XAS_PAGE_ADDR, 8'hf6);
    move(0, 0, 16'h0000, 8'h00, 0, 4'hc);
    move(1, 1, 16'hf7ff, 8'h00, 0, 4'h7);
    move(1, 1, 16'h1234, 8'h3c, 0, 4'he);
    move(0, 1, 16'h1234, 8'h00, 0, 4'he);
    chk("ext rdata", 8'h3c, rdat);
    sw(XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h02);
    move(1, 1, 16'hf840, 8'hc3, 0, 4'he);
    sw(XAS_SYSTEM_CONTROL_REGISTER_ADDR, 8'h00);
    ea = 1'b1;
    repeat (4) @(negedge i_mclk);
    move(0, 1, 16'hf840, 8'h00, 0, 4'h0);
    chk("ram rdata", 8'hc3, rdat);
    ea = 1'b0;
    repeat (4) @(negedge i_mclk);
    move(1, 1, 16'hf840, 8'h11, 1, 4'h6);
    move(0, 1, 16'hf840, 8'h00, 0, 4'h6);
    chk("ram rdata", 8'hc3, rdat);
    move(1, 1, 16'hf840, 8'h22, 2, 4'h6);
    move(0, 1, 16'hf840, 8'h00, 0, 4'h6);
    chk("ram rdata", 8'h22, rdat);
    finish_test;
  end
endmodule // test_xas_steering

// >>> verification/xas_ext_mem.sv
// xas_ext_mem: behavioural external data memory on the multiplexed bus
// assumes active-low strobes held for both move cycles
`timescale 1ns/1ns
module xas_ext_mem
(
  input  wire logic        i_mclk,
  input  wire logic        i_rd_b,
  input  wire logic        i_wr_b,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:65535];
  initial o_rdata = 8'h5a;
  // read data lands one edge after the strobe; a released bus inverts the last value again on every edge
  always @(posedge i_mclk)
  begin
    if (!i_wr_b) mem[i_addr] <= i_wdata;
    if (!i_rd_b) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
  end
endmodule // xas_ext_mem
